// ---- porta_pkg.sv ----
package porta_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [3:0] OFS_DATA_LATCH  = 4'h0;
   localparam logic [3:0] OFS_DIRECTION   = 4'h1;
   localparam logic [3:0] OFS_PULL_HIGH   = 4'h2;
   localparam logic [3:0] OFS_WAKE_EN     = 4'h3;
   localparam logic [3:0] OFS_FUNC_LOW    = 4'h4;
   localparam logic [3:0] OFS_FUNC_HIGH   = 4'h5;
   localparam logic [3:0] OFS_INPUT_SEL   = 4'h6;
   localparam logic [3:0] OFS_STATUS      = 4'h7;

   // ****************************************
   // Reset values and masks
   // ****************************************
   localparam logic [7:0] RST_DATA_LATCH  = 8'hff;
   localparam logic [7:0] RST_DIRECTION   = 8'hff;
   localparam logic [7:0] RST_PULL_HIGH   = 8'h00;
   localparam logic [7:0] RST_WAKE_EN     = 8'h00;
   localparam logic [7:0] RST_FUNC_LOW    = 8'h00;
   localparam logic [7:0] RST_FUNC_HIGH   = 8'h00;
   localparam logic [7:0] RST_INPUT_SEL   = 8'h00;
   localparam logic [7:0] MASK_FUNC_HIGH  = 8'hcf;
   localparam logic [7:0] MASK_INPUT_SEL  = 8'h03;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int FLD_PIN3 = 6;
   localparam int FLD_PIN2 = 4;
   localparam int FLD_PIN1 = 2;
   localparam int FLD_PIN0 = 0;
   localparam int FLD_PIN7 = 6;
   localparam int FLD_PIN5 = 2;
   localparam int FLD_PIN4 = 0;
   localparam int BIT_TIMER_CLK_SRC = 1;
   localparam int BIT_EXT_IRQ_SRC   = 0;

   // ****************************************
   // Function codes
   // ****************************************
   localparam logic [1:0] FN_ALT  = 2'h3;
   localparam logic [1:0] FN_TINV = 2'h2;
endpackage : porta_pkg

// ---- port_a_gpio_wake_pinmux.sv ----
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
// Overview of operation
// - Falling edge on enabled pin wakes sleeping device
// - Wake only for GPIO input during sleep
// - Wake enable bits read/write, reset zero
// - Direction bit one input, zero CMOS output
// - Input pin reads its pin level
// - Output pin reads data latch, not pin
// - Latch and direction reset to all ones
// - Unwritten output drives high from latch
// - Bit set/clear is byte read-modify-write
// - Pin 3 code 11 gives touch key 3
// - Pin 2: 10 inverted timer, 11 SDA
// - Pin 1 code 11 gives touch key 2
// - Pin 0: GPIO/timer clock/irq, 11 SCL
// - Pin 7 code 11 gives timer output
// - Pin 5 code 11 gives touch key 1
// - Pin 4 code 11 gives touch key 4
// - Unimplemented select bits read as zero
// - Timer clock source: 0 pin6, 1 pin0
// - Interrupt source: 0 pin0, 1 pin6
// - Pull-high only for input pins
module port_a_gpio_wake_pinmux
   import porta_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RESET,
   // Register port
   input  wire logic [3:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output logic      [7:0] REG_RDATA,
   // Power state
   input  wire logic       SLEEP_IDLE,
   output logic            WAKE_REQ,
   // Port pins
   input  wire logic [7:0] PIN_IN,
   output logic      [7:0] PIN_OUT,
   output logic      [7:0] PIN_OE,
   output logic      [7:0] PULL_HIGH_ON,
   // Peripheral side
   input  wire logic       TIMER_OUTPUT,
   input  wire logic       SDA_OUT,
   input  wire logic       SDA_OE,
   input  wire logic       SCL_OUT,
   input  wire logic       SCL_OE,
   output logic            TIMER_EXT_CLOCK_IN,
   output logic            EXT_IRQ_IN,
   output logic            SDA_IN,
   output logic            SCL_IN,
   output logic      [3:0] TOUCH_KEY_SEL
);

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] port_data_latch_q;
   logic [7:0] pin_direction_ctrl_q;
   logic [7:0] pull_high_enable_q;
   logic [7:0] port_wake_enable_q;
   logic [7:0] pin_func_select_low_q;
   logic [7:0] pin_func_select_high_q;
   logic [7:0] input_source_select_q;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] prev_q;
   logic [7:0] wake_seen_q;
   logic [7:0] rdata_d;
   logic [7:0] is_alt;
   logic [7:0] out_d;
   logic [7:0] oe_d;
   logic [7:0] fall;

   // Decode a two-bit field as the alternate function code
   function automatic logic alt_sel(input logic [1:0] code);
      return code == FN_ALT;
   endfunction : alt_sel

   // Register writes; bit set/clear arrives as a whole-byte write
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         port_data_latch_q      <= RST_DATA_LATCH;
         pin_direction_ctrl_q   <= RST_DIRECTION;
         pull_high_enable_q     <= RST_PULL_HIGH;
         port_wake_enable_q     <= RST_WAKE_EN;
         pin_func_select_low_q  <= RST_FUNC_LOW;
         pin_func_select_high_q <= RST_FUNC_HIGH;
         input_source_select_q  <= RST_INPUT_SEL;
      end else if (REG_WR) begin
         unique case (REG_ADDR)
            OFS_DATA_LATCH: port_data_latch_q    <= REG_WDATA;
            OFS_DIRECTION:  pin_direction_ctrl_q <= REG_WDATA;
            OFS_PULL_HIGH:  pull_high_enable_q   <= REG_WDATA;
            OFS_WAKE_EN:    port_wake_enable_q   <= REG_WDATA;
            OFS_FUNC_LOW:   pin_func_select_low_q <= REG_WDATA;
            OFS_FUNC_HIGH:  pin_func_select_high_q <= REG_WDATA & MASK_FUNC_HIGH;
            OFS_INPUT_SEL:  input_source_select_q <= REG_WDATA & MASK_INPUT_SEL;
            default: begin
            end
         endcase
      end
   end

   // Pin synchroniser and edge history
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         sync1_q <= 8'hff;
         sync2_q <= 8'hff;
         prev_q  <= 8'hff;
      end else begin
         sync1_q <= PIN_IN;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // Alternate function flags per pin
   always_comb begin
      is_alt    = 8'h00;
      is_alt[3] = alt_sel(pin_func_select_low_q[FLD_PIN3 +: 2]);
      is_alt[2] = pin_func_select_low_q[FLD_PIN2 +: 2] == FN_ALT ||
                  pin_func_select_low_q[FLD_PIN2 +: 2] == FN_TINV;
      is_alt[1] = alt_sel(pin_func_select_low_q[FLD_PIN1 +: 2]);
      is_alt[0] = alt_sel(pin_func_select_low_q[FLD_PIN0 +: 2]);
      is_alt[7] = alt_sel(pin_func_select_high_q[FLD_PIN7 +: 2]);
      is_alt[5] = alt_sel(pin_func_select_high_q[FLD_PIN5 +: 2]);
      is_alt[4] = alt_sel(pin_func_select_high_q[FLD_PIN4 +: 2]);
   end

   // Pin drive: GPIO from latch, alternates from peripherals
   always_comb begin
      out_d = port_data_latch_q;
      oe_d  = ~pin_direction_ctrl_q;
      for (int i = 0; i < 8; i++) begin
         if (is_alt[i]) begin
            oe_d[i] = 1'b0;              // Touch key pins are analog
         end
      end
      if (pin_func_select_low_q[FLD_PIN2 +: 2] == FN_TINV) begin
         out_d[2] = ~TIMER_OUTPUT;
         oe_d[2]  = 1'b1;
      end else if (is_alt[2]) begin
         out_d[2] = SDA_OUT;
         oe_d[2]  = SDA_OE;
      end
      if (is_alt[0]) begin
         out_d[0] = SCL_OUT;
         oe_d[0]  = SCL_OE;
      end
      if (is_alt[7]) begin
         out_d[7] = TIMER_OUTPUT;
         oe_d[7]  = 1'b1;
      end
   end

   // Registered pin outputs and peripheral inputs
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         PIN_OUT            <= RST_DATA_LATCH;
         PIN_OE             <= 8'h00;
         PULL_HIGH_ON       <= 8'h00;
         TIMER_EXT_CLOCK_IN <= 1'b1;
         EXT_IRQ_IN         <= 1'b1;
         SDA_IN             <= 1'b1;
         SCL_IN             <= 1'b1;
         TOUCH_KEY_SEL      <= 4'h0;
      end else begin
         PIN_OUT      <= out_d;
         PIN_OE       <= oe_d;
         PULL_HIGH_ON <= pull_high_enable_q & pin_direction_ctrl_q & ~is_alt;
         TIMER_EXT_CLOCK_IN <= input_source_select_q[BIT_TIMER_CLK_SRC] ?
                               sync2_q[0] : sync2_q[6];
         EXT_IRQ_IN   <= input_source_select_q[BIT_EXT_IRQ_SRC] ?
                         sync2_q[6] : sync2_q[0];
         SDA_IN       <= sync2_q[2];
         SCL_IN       <= sync2_q[0];
         TOUCH_KEY_SEL <= {is_alt[4], is_alt[3], is_alt[1], is_alt[5]};
      end
   end

   // Falling edges on GPIO input pins with wake enabled
   assign fall = prev_q & ~sync2_q & port_wake_enable_q
                 & pin_direction_ctrl_q & ~is_alt;

   // Wake request: OR of enabled falling edges during sleep
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         WAKE_REQ    <= 1'b0;
         wake_seen_q <= 8'h00;
      end else begin
         WAKE_REQ    <= SLEEP_IDLE && (|fall);
         wake_seen_q <= fall;
      end
   end

   // Read mux: inputs show pin, outputs show latch
   always_comb begin
      rdata_d = 8'h00;
      unique case (REG_ADDR)
         OFS_DATA_LATCH: rdata_d = (pin_direction_ctrl_q & sync2_q) |
                                   (~pin_direction_ctrl_q & port_data_latch_q);
         OFS_DIRECTION:  rdata_d = pin_direction_ctrl_q;
         OFS_PULL_HIGH:  rdata_d = pull_high_enable_q;
         OFS_WAKE_EN:    rdata_d = port_wake_enable_q;
         OFS_FUNC_LOW:   rdata_d = pin_func_select_low_q;
         OFS_FUNC_HIGH:  rdata_d = pin_func_select_high_q & MASK_FUNC_HIGH;
         OFS_INPUT_SEL:  rdata_d = input_source_select_q & MASK_INPUT_SEL;
         OFS_STATUS:     rdata_d = wake_seen_q;
         default:        rdata_d = 8'h00;
      endcase
   end

   // Read data stands one cycle after the strobe
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         REG_RDATA <= 8'h00;
      end else begin
         REG_RDATA <= REG_RD ? rdata_d : 8'h00;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_wake_on_edge: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (SLEEP_IDLE && (|fall)) |=> WAKE_REQ)
      else $error("wake missed");
   a_no_wake_awake: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !$past(SLEEP_IDLE) |-> !WAKE_REQ)
      else $error("wake while awake");
   a_no_wake_output: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_direction_ctrl_q == 8'h00) |=> !WAKE_REQ)
      else $error("wake from output pin");
   a_wake_en_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (REG_WR && REG_ADDR == OFS_WAKE_EN) ##2 (REG_RD && REG_ADDR == OFS_WAKE_EN
      && !REG_WR) |=> REG_RDATA == $past(REG_WDATA, 3))
      else $error("wake enable readback");
   a_out_drive: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (!pin_direction_ctrl_q[6]) |=> PIN_OE[6] && PIN_OUT[6] == $past(port_data_latch_q[6]))
      else $error("output pin not driven");
   a_in_float: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_direction_ctrl_q[6]) |=> !PIN_OE[6])
      else $error("input pin driven");
   a_read_out_latch: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (REG_RD && REG_ADDR == OFS_DATA_LATCH && pin_direction_ctrl_q == 8'h00)
      |=> REG_RDATA == $past(port_data_latch_q))
      else $error("output read not latch");
   a_reset_high: assert property (@(posedge CLK_SYS)
      RESET |=> port_data_latch_q == 8'hff && pin_direction_ctrl_q == 8'hff)
      else $error("reset values wrong");
   a_unimpl_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (REG_RD && REG_ADDR == OFS_INPUT_SEL) |=> REG_RDATA[7:2] == 6'h00)
      else $error("unimplemented bits set");
   a_tclk_src: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (!input_source_select_q[1]) |=> TIMER_EXT_CLOCK_IN == $past(sync2_q[6]))
      else $error("timer clock source wrong");
   a_irq_src: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (!input_source_select_q[0]) |=> EXT_IRQ_IN == $past(sync2_q[0]))
      else $error("irq source wrong");
   a_pull_output: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (!pin_direction_ctrl_q[1]) |=> !PULL_HIGH_ON[1])
      else $error("pull-high on output");

   // ****************************************
   // Register and pin-mux assertions
   // ****************************************

   // Read data is zero outside the read slot
   a_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data outside slot");

   // Direction write lands next cycle
   a_dir_write: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (REG_WR && REG_ADDR == OFS_DIRECTION) |=> pin_direction_ctrl_q == $past(REG_WDATA))
      else $error("direction write lost");

   // Wake enable write lands next cycle
   a_wake_en_write: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (REG_WR && REG_ADDR == OFS_WAKE_EN) |=> port_wake_enable_q == $past(REG_WDATA))
      else $error("wake enable write lost");

   // Whole-byte latch write lands next cycle
   a_latch_write: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (REG_WR && REG_ADDR == OFS_DATA_LATCH) |=> port_data_latch_q == $past(REG_WDATA))
      else $error("latch write lost");

   // Unimplemented high select bits stay zero
   a_func_high_mask: assert property (@(posedge CLK_SYS) disable iff (RESET)
      pin_func_select_high_q[5:4] == 2'h0)
      else $error("high select spare bits set");

   // Unimplemented input select bits stay zero
   a_input_sel_mask: assert property (@(posedge CLK_SYS) disable iff (RESET)
      input_source_select_q[7:2] == 6'h00)
      else $error("input select spare bits set");

   // All-input port reads the synchronised pins
   a_read_in_pin: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (REG_RD && REG_ADDR == OFS_DATA_LATCH && pin_direction_ctrl_q == 8'hff)
      |=> REG_RDATA == $past(sync2_q))
      else $error("input read not pin");

   // Timer clock taken from pin 0 when selected
   a_tclk_pin0: assert property (@(posedge CLK_SYS) disable iff (RESET)
      input_source_select_q[1] |=> TIMER_EXT_CLOCK_IN == $past(sync2_q[0]))
      else $error("timer clock not from pin 0");

   // Interrupt taken from pin 6 when selected
   a_irq_pin6: assert property (@(posedge CLK_SYS) disable iff (RESET)
      input_source_select_q[0] |=> EXT_IRQ_IN == $past(sync2_q[6]))
      else $error("irq not from pin 6");

   // Pin 3 touch key select, driver off
   a_touch_key_3_sel: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_low_q[7:6] == FN_ALT) |=> TOUCH_KEY_SEL[2] && !PIN_OE[3])
      else $error("touch key 3 select");

   // Pin 3 general codes leave the key off
   a_touch_key_3_gpio: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_low_q[7:6] != FN_ALT) |=> !TOUCH_KEY_SEL[2])
      else $error("touch key 3 without code");

   // Pin 1 touch key select, driver off
   a_touch_key_2_sel: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_low_q[3:2] == FN_ALT) |=> TOUCH_KEY_SEL[1] && !PIN_OE[1])
      else $error("touch key 2 select");

   // Pin 5 touch key select, driver off
   a_touch_key_1_sel: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_high_q[3:2] == FN_ALT) |=> TOUCH_KEY_SEL[0] && !PIN_OE[5])
      else $error("touch key 1 select");

   // Pin 4 touch key select, driver off
   a_touch_key_4_sel: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_high_q[1:0] == FN_ALT) |=> TOUCH_KEY_SEL[3] && !PIN_OE[4])
      else $error("touch key 4 select");

   // Pin 2 drives the inverted timer output
   a_tinv_drive: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_low_q[5:4] == FN_TINV)
      |=> PIN_OE[2] && PIN_OUT[2] == !$past(TIMER_OUTPUT))
      else $error("inverted timer pin wrong");

   // Pin 2 follows the data line peripheral
   a_sda_drive: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_low_q[5:4] == FN_ALT)
      |=> PIN_OE[2] == $past(SDA_OE) && PIN_OUT[2] == $past(SDA_OUT))
      else $error("data line pin wrong");

   // Pin 2 general codes follow direction
   a_pin2_gpio: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !pin_func_select_low_q[5] |=> PIN_OE[2] == !$past(pin_direction_ctrl_q[2]))
      else $error("pin 2 general drive wrong");

   // Pin 0 follows the clock line peripheral
   a_scl_drive: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_low_q[1:0] == FN_ALT)
      |=> PIN_OE[0] == $past(SCL_OE) && PIN_OUT[0] == $past(SCL_OUT))
      else $error("clock line pin wrong");

   // Pin 7 drives the timer output
   a_ctp_drive: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_high_q[7:6] == FN_ALT)
      |=> PIN_OE[7] && PIN_OUT[7] == $past(TIMER_OUTPUT))
      else $error("timer pin wrong");

   // Enabled pull-high on an input pin is on
   a_pull_input: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_direction_ctrl_q[6] && pull_high_enable_q[6]) |=> PULL_HIGH_ON[6])
      else $error("pull-high missing on input");

   // Alternate function on pin 2 blocks its wake
   a_wake_alt_pin: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (pin_func_select_low_q[5:4] == FN_ALT && port_wake_enable_q == 8'h04)
      |=> !WAKE_REQ)
      else $error("wake from alternate pin");

   // Pins reach the second stage two cycles later
   a_sync_path: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (!$past(RESET) && !$past(RESET, 2)) |-> sync2_q == $past(PIN_IN, 2))
      else $error("pin synchroniser delay wrong");

   // Status read shows the last edge set
   a_status_read: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (REG_RD && REG_ADDR == OFS_STATUS) |=> REG_RDATA == $past(wake_seen_q))
      else $error("edge status read wrong");

endmodule : port_a_gpio_wake_pinmux

// ---- pin_switch_model.sv ----
`timescale 1ns/10ps
// ****************************************
// External switches on the port pins
// ****************************************
module pin_switch_model (
   // Clock
   input  wire logic       CLK_SYS,
   // Device pin side
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pull_on,
   // Switch control
   input  wire logic [7:0] sw_drive,
   input  wire logic [7:0] sw_level,
   output logic      [7:0] pin_level
);
   logic [7:0] last_q = 8'h00;

   // Remember the wire so a floating pin can wander
   always_ff @(posedge CLK_SYS) begin
      last_q <= pin_level;
   end

   // Device drive wins, then switch, then pull, else floating
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) begin
            pin_level[i] = pin_out[i];
         end else if (sw_drive[i]) begin
            pin_level[i] = sw_level[i];
         end else if (pull_on[i]) begin
            pin_level[i] = 1'b1;
         end else begin
            pin_level[i] = ~last_q[i];
         end
      end
   end
endmodule : pin_switch_model

// ---- port_a_gpio_wake_pinmux_tb.sv ----
`timescale 1ns/10ps
module port_a_gpio_wake_pinmux_tb;
   import porta_pkg::*;
   // ****************************************
   // Signals and tables
   // ****************************************
   logic       CLK_SYS = 0, RESET = 1, REG_WR = 0, REG_RD = 0, SLEEP_IDLE = 0;
   logic       TIMER_OUTPUT = 0, SDA_OUT = 1, SDA_OE = 0, SCL_OUT = 1, SCL_OE = 0;
   logic [3:0] REG_ADDR = 4'h0;
   logic [7:0] REG_WDATA = 8'h00, sw_drive = 8'hff, sw_level = 8'ha5, v;
   logic [7:0] REG_RDATA, PIN_IN, PIN_OUT, PIN_OE, PULL_HIGH_ON;
   logic       WAKE_REQ, TIMER_EXT_CLOCK_IN, EXT_IRQ_IN, SDA_IN, SCL_IN, got;
   logic [3:0] TOUCH_KEY_SEL;
   int         miscompares = 0, n_tests = 0;
   logic [7:0] rst_e [9] = '{8'ha5, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [3:0] ma [4] = '{OFS_FUNC_HIGH, OFS_INPUT_SEL, OFS_WAKE_EN, 4'h8};
   logic [7:0] me [4] = '{8'hcf, 8'h03, 8'hff, 8'h00};
   logic [3:0] fa [4] = '{OFS_FUNC_LOW, OFS_FUNC_LOW, OFS_FUNC_HIGH, OFS_FUNC_HIGH};
   int         fs [4] = '{FLD_PIN3, FLD_PIN1, FLD_PIN5, FLD_PIN4};
   logic [3:0] fk [4] = '{4'h4, 4'h2, 4'h1, 4'h8};
   logic       ws [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   logic       we [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
   logic [7:0] wf [4] = '{8'h00, 8'h00, 8'h30, 8'h00};
   logic [7:0] wl [4] = '{8'hfb, 8'hfb, 8'hfb, 8'hf7};

   // Design and pin partner
   port_a_gpio_wake_pinmux u_port_a_gpio_wake_pinmux (
      .CLK_SYS(CLK_SYS), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SLEEP_IDLE(SLEEP_IDLE),
      .WAKE_REQ(WAKE_REQ), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
      .PULL_HIGH_ON(PULL_HIGH_ON), .TIMER_OUTPUT(TIMER_OUTPUT), .SDA_OUT(SDA_OUT),
      .SDA_OE(SDA_OE), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
      .TIMER_EXT_CLOCK_IN(TIMER_EXT_CLOCK_IN), .EXT_IRQ_IN(EXT_IRQ_IN),
      .SDA_IN(SDA_IN), .SCL_IN(SCL_IN), .TOUCH_KEY_SEL(TOUCH_KEY_SEL));
   pin_switch_model u_pin_switch_model (
      .CLK_SYS(CLK_SYS), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pull_on(PULL_HIGH_ON),
      .sw_drive(sw_drive), .sw_level(sw_level), .pin_level(PIN_IN));

   // 10 MHz clock
   initial begin
      forever #50 CLK_SYS = ~CLK_SYS;
   end

   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge CLK_SYS);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask : rd

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Bounded watch for a wake pulse
   task automatic wake_seen(output logic g);
      g = 1'b0;
      repeat (8) begin
         @(posedge CLK_SYS);
         #1 if (WAKE_REQ === 1'b1) g = 1'b1;
      end
   endtask : wake_seen

   task automatic summarize;
      if (miscompares == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge CLK_SYS);
      RESET <= 1'b0;
      repeat (2) @(posedge CLK_SYS); // Let pin levels through the synchroniser
      // Reset values over every offset and one unmapped index
      for (int i = 0; i < 9; i++) begin
         rd(i[3:0], v);
         chk("reset read", v, rst_e[i]);
      end
      // Pull-high follows direction
      wr(OFS_PULL_HIGH, 8'hff);
      sw_drive <= 8'h0f;
      wr(OFS_DIRECTION, 8'h0f);
      repeat (2) @(posedge CLK_SYS);
      chk("pull on", PULL_HIGH_ON, 8'h0f);
      chk("drive enable", PIN_OE, 8'hf0);
      chk("unwritten drive", PIN_OUT & 8'hf0, 8'hf0);
      rd(OFS_DATA_LATCH, v);
      chk("mixed read", v, 8'hf5);
      wr(OFS_DATA_LATCH, 8'h3c);
      rd(OFS_DATA_LATCH, v);
      chk("latch read", v, 8'h35);
      chk("latch drive", PIN_OUT & 8'hf0, 8'h30);
      rd(OFS_DIRECTION, v);
      wr(OFS_DIRECTION, v | 8'h10);
      rd(OFS_DIRECTION, v);
      chk("bit set", v, 8'h1f);
      // Implemented bits only
      for (int i = 0; i < 4; i++) begin
         wr(ma[i], 8'hff);
         rd(ma[i], v);
         chk("masked write", v, me[i]);
         wr(ma[i], 8'h00);
      end
      // Every code of every touch-key field
      for (int i = 0; i < 4; i++) begin
         for (int c = 0; c < 4; c++) begin
            wr(fa[i], 8'(c) << fs[i]);
            repeat (2) @(posedge CLK_SYS);
            chk("touch select", {4'h0, TOUCH_KEY_SEL}, (c == 3) ? {4'h0, fk[i]} : 8'h00);
         end
         wr(fa[i], 8'h00);
      end
      // Timer outputs on pins 7 and 2
      sw_drive <= 8'h00;
      wr(OFS_DATA_LATCH, 8'hff);
      wr(OFS_DIRECTION, 8'h00);
      wr(OFS_FUNC_HIGH, 8'hc0);
      wr(OFS_FUNC_LOW, 8'h20);
      for (int t = 0; t < 2; t++) begin
         TIMER_OUTPUT <= t[0];
         repeat (3) @(posedge CLK_SYS);
         chk("timer pins", PIN_OUT & 8'h84, (t == 1) ? 8'h80 : 8'h04);
      end
      // I2C pins, function chosen before the peripheral drives
      wr(OFS_FUNC_LOW, 8'h33);
      SDA_OE <= 1'b1;
      SDA_OUT <= 1'b0;
      SCL_OE <= 1'b1;
      SCL_OUT <= 1'b0;
      repeat (6) @(posedge CLK_SYS);
      chk("i2c pins", {2'h0, PIN_OUT[2], PIN_OUT[0], PIN_OE[2], PIN_OE[0], SDA_IN, SCL_IN}, 8'h0c);
      SDA_OE <= 1'b0;
      SCL_OE <= 1'b0;
      wr(OFS_FUNC_LOW, 8'h00);
      wr(OFS_FUNC_HIGH, 8'h00);
      wr(OFS_DIRECTION, 8'hff);
      // Source pin choice for timer clock and interrupt inputs
      sw_drive <= 8'hff;
      sw_level <= 8'h01;
      for (int s = 0; s < 2; s++) begin
         wr(OFS_INPUT_SEL, (s == 1) ? 8'h03 : 8'h00);
         repeat (5) @(posedge CLK_SYS);
         chk("input source", {6'h0, TIMER_EXT_CLOCK_IN, EXT_IRQ_IN}, (s == 1) ? 8'h02 : 8'h01);
      end
      // Wake on pin 2 only: asleep, awake, alternate function, other pin
      sw_level <= 8'hff;
      wr(OFS_WAKE_EN, 8'h04);
      for (int i = 0; i < 4; i++) begin
         SLEEP_IDLE <= ws[i];
         wr(OFS_FUNC_LOW, wf[i]);
         repeat (4) @(posedge CLK_SYS);
         sw_level <= wl[i];
         wake_seen(got);
         chk("wake", {7'h0, got}, {7'h0, we[i]});
         sw_level <= 8'hff;
         repeat (4) @(posedge CLK_SYS);
      end
      summarize();
   end
endmodule : port_a_gpio_wake_pinmux_tb
